/* File: core/ddrpd_params.svh */
`ifndef DDRPD_PARAMS_SVH
`define DDRPD_PARAMS_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define DDRPD_REG_CTRL      8'h00
`define DDRPD_REG_STATUS    8'h04
`define DDRPD_REG_REFCNT    8'h08

// ----------------------------------------
// field positions
// ----------------------------------------
`define DDRPD_CTRL_SLOW     0
`define DDRPD_ST_SREF       8
`define DDRPD_ST_PDPRE      9
`define DDRPD_ST_PDACT      10
`define DDRPD_ST_RFBUSY     11
`define DDRPD_ST_XSWAIT     12
`define DDRPD_ST_ERR        13

// ----------------------------------------
// reset values
// ----------------------------------------
`define DDRPD_CTRL_RST      1'b0

// ----------------------------------------
// timing counts in link clock cycles
// ----------------------------------------
`define DDRPD_TRFC_CK       8'h33
`define DDRPD_TXSRD_CK      8'hc8

`endif

/* File: core/ddrpd_pkg.sv */
package ddrpd_pkg;

  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_ACT,
    CMD_RD,
    CMD_WR,
    CMD_PRE,
    CMD_REF,
    CMD_LM
  } ddrpd_cmd_e;

  typedef enum logic [1:0] {
    ST_NORM,
    ST_PD_PRE,
    ST_PD_ACT,
    ST_SREF
  } ddrpd_state_e;

  // command and control pins, sampled as one group
  typedef struct packed {
    logic       cke;
    logic       cs_n;
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic [2:0] ba;
    logic       a10;
    logic       odt;
  } ddrpd_pins_s;

endpackage

/* File: core/ddrpd_core.sv */
`timescale 1ns/1ps
`include "ddrpd_params.svh"
// Summary of operation
// (RULE1) precharge or auto precharge closes open rows
// (RULE2) A10 high closes all, else named bank
// (RULE3) controller activates bank before read or write
// (RULE4) controller waits precharge time before reuse
// (RULE5) controller refreshes every 7.8125us on average
// (RULE6) refresh busy from registering edge for tRFC
// (RULE7) above 85C refresh interval 3.9us maximum
// (RULE8) refresh with CKE low enters self refresh
// (RULE9) stable clock, then only NOPs for tXSNR
// (RULE10) simple approach: 200 NOP cycles after exit
// (RULE11) tXSNR before non-read, 200 before read
// (RULE12) CKE stays high until tXSRD, except re-entry
// (RULE13) ODT off before self refresh, low after
// (RULE14) self refresh only with banks idle
// (RULE15) CKE high throughout read and write bursts
// (RULE16) CKE low with NOP enters power-down
// (RULE17) idle banks precharge, open rows active power-down
// (RULE18) power-down gates buffers, precharge mode freezes DLL
// (RULE19) clock frequency change only in precharge power-down
// (RULE20) CKE stable three registering edges after change
// (RULE21) tXP, tXARD or tXARDS after power-down exit
// (RULE22) no column access at entry, DLL reset
// (RULE23) track bank state, reject unsafe self refresh
module ddrpd_core
  import ddrpd_pkg::*;
(
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  // memory link pins
  input  wire logic        i_ck,
  input  wire ddrpd_pins_s i_pins,
  // register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // device state
  output logic      [7:0]  o_bank_open,
  output logic             o_refresh_busy,
  output logic             o_sref,
  output logic             o_pd_pre,
  output logic             o_pd_act,
  output logic             o_buf_en,
  output logic             o_dll_frozen,
  output logic             o_cmd_err
);

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  function automatic ddrpd_cmd_e dec_cmd(input ddrpd_pins_s p);
    ddrpd_cmd_e c;
    c = CMD_NOP;
    if (!p.cs_n) begin
      case ({p.ras_n, p.cas_n, p.we_n})
        3'h3:    c = CMD_ACT;
        3'h5:    c = CMD_RD;
        3'h4:    c = CMD_WR;
        3'h2:    c = CMD_PRE;
        3'h1:    c = CMD_REF;
        3'h0:    c = CMD_LM;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic        ck_s1;
  logic        ck_s2;
  logic        ck_s3;
  ddrpd_pins_s pin_s1;
  ddrpd_pins_s pin_s2;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ck_s1  <= 1'b0;
      ck_s2  <= 1'b0;
      ck_s3  <= 1'b0;
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      ck_s1  <= i_ck;
      ck_s2  <= ck_s1;
      ck_s3  <= ck_s2;
      pin_s1 <= i_pins;
      pin_s2 <= pin_s1;
    end
  end

  // pins travel the same two stages as the clock, so they are
  // sampled at the synchronised rising edge with full setup margin
  logic       ck_rise;
  ddrpd_cmd_e cmd;
  logic       cke;
  logic       a10;
  logic [2:0] ba;

  assign ck_rise = ck_s2 & ~ck_s3;
  assign cmd     = dec_cmd(pin_s2);
  assign cke     = pin_s2.cke;
  assign a10     = pin_s2.a10;
  assign ba      = pin_s2.ba;

  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  ddrpd_state_e st;
  logic         cke_prev;
  logic [7:0]   bank_open;
  logic [7:0]   rfc_cnt;
  logic [7:0]   xs_cnt;
  logic [15:0]  ref_cnt;
  logic         slow_exit;
  logic         err;

  logic norm_edge;
  logic cke_fall;
  logic cke_rise;
  logic sref_entry;
  logic sref_bad;
  logic pd_entry;
  logic err_set;
  logic err_clr;

  assign norm_edge  = ck_rise && st == ST_NORM && cke_prev && cke;
  assign cke_fall   = ck_rise && st == ST_NORM && cke_prev && !cke;
  assign cke_rise   = ck_rise && st != ST_NORM && cke;
  assign sref_entry = cke_fall && cmd == CMD_REF && bank_open == 8'h00;
  assign sref_bad   = cke_fall && cmd == CMD_REF && bank_open != 8'h00;
  assign pd_entry   = cke_fall && cmd == CMD_NOP;
  assign err_set    = sref_bad || (cke_fall && cmd != CMD_REF && cmd != CMD_NOP);
  assign err_clr    = i_wr && i_addr == `DDRPD_REG_STATUS && i_wdata[`DDRPD_ST_ERR];

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cke_prev <= 1'b0;
    end else if (ck_rise) begin
      cke_prev <= cke;
    end
  end

  // ----------------------------------------
  // power state
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= ST_NORM;
    end else begin
      case (st)
        ST_NORM: begin
          if (sref_entry) begin
            st <= ST_SREF; // see (RULE8)
          end else if (pd_entry) begin
            st <= (bank_open == 8'h00) ? ST_PD_PRE : ST_PD_ACT; // see (RULE17)
          end
        end
        ST_PD_PRE,
        ST_PD_ACT,
        ST_SREF: begin
          if (cke_rise) begin
            st <= ST_NORM; // see (RULE16)
          end
        end
        default: st <= ST_NORM;
      endcase
    end
  end
  a_sref_entry: // see (RULE8)
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      sref_entry |=> st == ST_SREF ##1 (o_sref && o_dll_frozen))
    else $error("self refresh not entered");
  a_pd_exit_sync: // see (RULE16)
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      cke_rise |=> st == ST_NORM ##1 o_buf_en)
    else $error("power-down not left on registered cke high");
  a_pd_kind: // see (RULE17)
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      pd_entry |=> (st == ST_PD_PRE) == ($past(bank_open) == 8'h00))
    else $error("wrong power-down kind");

  // ----------------------------------------
  // bank tracking
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bank_open <= 8'h00;
    end else if (norm_edge) begin
      case (cmd)
        CMD_ACT: bank_open[ba] <= 1'b1; // see (RULE23)
        CMD_PRE: begin
          if (a10) begin
            bank_open <= 8'h00; // see (RULE2)
          end else begin
            bank_open[ba] <= 1'b0; // see (RULE1)
          end
        end
        // auto precharge closed at the command; data timing is not modelled
        CMD_RD,
        CMD_WR: begin
          if (a10) begin
            bank_open[ba] <= 1'b0; // see (RULE1)
          end
        end
        default: bank_open <= bank_open;
      endcase
    end
  end
  a_pre_all_banks: // see (RULE2)
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      norm_edge && cmd == CMD_PRE && a10 |=> bank_open == 8'h00)
    else $error("precharge all left a bank open");
  a_pre_one_bank: // see (RULE1)
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      norm_edge && (cmd == CMD_PRE || ((cmd == CMD_RD || cmd == CMD_WR) && a10)) |=> !bank_open[$past(ba)])
    else $error("precharged bank left open");

  // ----------------------------------------
  // refresh and self refresh exit timing
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rfc_cnt <= 8'h00;
    end else if (norm_edge && cmd == CMD_REF) begin
      rfc_cnt <= `DDRPD_TRFC_CK; // see (RULE6)
    end else if (ck_rise && rfc_cnt != 8'h00) begin
      rfc_cnt <= rfc_cnt - 8'h01;
    end
  end
  a_refresh_busy: // see (RULE6)
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      norm_edge && cmd == CMD_REF |-> ##2 o_refresh_busy [*8])
    else $error("refresh not busy after command");

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ref_cnt <= 16'h0000;
    end else if ((norm_edge && cmd == CMD_REF) || sref_entry) begin
      ref_cnt <= ref_cnt + 16'h0001;
    end
  end

  // exit window shown to software; the controller owns the wait
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      xs_cnt <= 8'h00;
    end else if (cke_rise && st == ST_SREF) begin
      xs_cnt <= `DDRPD_TXSRD_CK;
    end else if (ck_rise && xs_cnt != 8'h00) begin
      xs_cnt <= xs_cnt - 8'h01;
    end
  end

  // ----------------------------------------
  // error flag: set wins over clear
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      err <= 1'b0;
    end else if (err_set) begin
      err <= 1'b1; // see (RULE23)
    end else if (err_clr) begin
      err <= 1'b0;
    end
  end
  a_sref_reject: // see (RULE23)
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      sref_bad |=> st == ST_NORM ##1 o_cmd_err)
    else $error("self refresh accepted with open bank");

  // ----------------------------------------
  // register port
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      slow_exit <= `DDRPD_CTRL_RST;
    end else if (i_wr && i_addr == `DDRPD_REG_CTRL) begin
      slow_exit <= i_wdata[`DDRPD_CTRL_SLOW];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      case (i_addr)
        `DDRPD_REG_CTRL:   o_rdata <= {31'h0, slow_exit};
        `DDRPD_REG_STATUS: o_rdata <= {18'h0, err, xs_cnt != 8'h00, rfc_cnt != 8'h00,
                                       st == ST_PD_ACT, st == ST_PD_PRE, st == ST_SREF, bank_open};
        `DDRPD_REG_REFCNT: o_rdata <= {16'h0, ref_cnt};
        default:           o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bank_open    <= 8'h00;
      o_refresh_busy <= 1'b0;
      o_sref         <= 1'b0;
      o_pd_pre       <= 1'b0;
      o_pd_act       <= 1'b0;
      o_buf_en       <= 1'b1;
      o_dll_frozen   <= 1'b0;
      o_cmd_err      <= 1'b0;
    end else begin
      o_bank_open    <= bank_open;
      o_refresh_busy <= rfc_cnt != 8'h00 || st == ST_SREF; // see (RULE6)
      o_sref         <= st == ST_SREF;
      o_pd_pre       <= st == ST_PD_PRE;
      o_pd_act       <= st == ST_PD_ACT;
      o_buf_en       <= st == ST_NORM; // see (RULE18)
      // slow exit lets active power-down freeze the DLL as well
      o_dll_frozen   <= st == ST_PD_PRE || st == ST_SREF || (st == ST_PD_ACT && slow_exit); // see (RULE18)
      o_cmd_err      <= err;
    end
  end
  a_pd_buffers: // see (RULE18)
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      st == ST_PD_PRE |-> ##1 (!o_buf_en && o_dll_frozen && o_pd_pre))
    else $error("buffers or dll live in precharge power-down");

endmodule

/* File: bench/ddrpd_ctrl_model.sv */
`timescale 1ns/1ps
module ddrpd_ctrl_model
  import ddrpd_pkg::*;
(
  // link pins
  output logic        o_ck,
  output ddrpd_pins_s o_pins
);
  // ----------------------------------------
  // clock
  // ----------------------------------------
  // runs free at one rate: stable clock in power-down and self refresh
  initial begin
    o_ck = 1'b0;
    forever #40 o_ck = ~o_ck;
  end

  initial o_pins = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 1'b0, 1'b0};

  // ----------------------------------------
  // command tasks
  // ----------------------------------------
  // pins move on the falling edge so they sit still around the sampling edge;
  // odt is never raised, so termination is off around self refresh
  task automatic send(input ddrpd_cmd_e c, input logic cke, input logic [2:0] ba, input logic a10);
    logic [2:0] code;
    case (c)
      CMD_ACT: code = 3'h3;
      CMD_RD:  code = 3'h5;
      CMD_WR:  code = 3'h4;
      CMD_PRE: code = 3'h2;
      CMD_REF: code = 3'h1;
      CMD_LM:  code = 3'h0;
      default: code = 3'h7;
    endcase
    @(negedge o_ck);
    o_pins = '{cke, c == CMD_NOP, code[2], code[1], code[0], ba, a10, 1'b0};
    @(posedge o_ck);
    @(negedge o_ck);
    o_pins = '{cke, 1'b1, ~o_pins.ras_n, ~o_pins.cas_n, ~o_pins.we_n, ~o_pins.ba, ~o_pins.a10, 1'b0};
  endtask

  // deselect only; the ignored lines keep changing
  task automatic idle(input int n, input logic cke);
    repeat (n) begin
      @(posedge o_ck);
      @(negedge o_ck);
      o_pins = '{cke, 1'b1, ~o_pins.ras_n, ~o_pins.cas_n, ~o_pins.we_n, ~o_pins.ba, ~o_pins.a10, 1'b0};
    end
  endtask
endmodule

/* File: bench/ddr2_precharge_refresh_powerdown_test.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module ddr2_precharge_refresh_powerdown_test
  import ddrpd_pkg::*;
;
  logic        i_core_clk;
  logic        i_rst_n;
  logic        ck;
  ddrpd_pins_s pins;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic [7:0]  o_bank_open;
  logic        o_refresh_busy;
  logic        o_sref;
  logic        o_pd_pre;
  logic        o_pd_act;
  logic        o_buf_en;
  logic        o_dll_frozen;
  logic        o_cmd_err;
  logic [31:0] d;
  int          mismatches;
  int          compares;
  // precharge-all recovery in link cycles; plain default
  localparam int TRPA_CK = 3;

  ddrpd_ctrl_model u_ctrl (.o_ck(ck), .o_pins(pins));

  ddrpd_core u_dut (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ck(ck), .i_pins(pins),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_bank_open(o_bank_open), .o_refresh_busy(o_refresh_busy), .o_sref(o_sref),
    .o_pd_pre(o_pd_pre), .o_pd_act(o_pd_act), .o_buf_en(o_buf_en),
    .o_dll_frozen(o_dll_frozen), .o_cmd_err(o_cmd_err)
  );

  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end

  // ----------------------------------------
  // register port tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_core_clk);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    `CHK(v, exp)
  endtask

  task automatic conclude;
    if (mismatches == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // a full run is about 27 us of link traffic
  initial begin
    #100000;
    mismatches++;
    conclude();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    mismatches = 0;
    compares   = 0;
    i_rst_n    = 1'b0;
    i_addr     = 8'h00;
    i_wdata    = 32'h0;
    i_wr       = 1'b0;
    i_rd       = 1'b0;
    repeat (8) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    `CHK({o_buf_en, o_bank_open, o_sref, o_cmd_err}, 11'h400)
    rchk(8'h00, 32'h0);
    rchk(8'h08, 32'h0);
    rchk(8'h0c, 32'h0);
    u_ctrl.idle(3, 1'b1);
    for (int b = 0; b < 8; b++) u_ctrl.send(CMD_ACT, 1'b1, b[2:0], 1'b0);
    `CHK(o_bank_open, 8'hff)
    u_ctrl.send(CMD_PRE, 1'b1, 3'h3, 1'b0);
    `CHK(o_bank_open, 8'hf7)
    u_ctrl.send(CMD_RD, 1'b1, 3'h5, 1'b1);
    `CHK(o_bank_open, 8'hd7)
    u_ctrl.send(CMD_PRE, 1'b1, 3'h3, 1'b1);
    `CHK(o_bank_open, 8'h00)
    u_ctrl.idle(TRPA_CK, 1'b1);
    // refresh stays busy for 0x33 link cycles; case kept below 85C, next refresh is self refresh
    u_ctrl.send(CMD_REF, 1'b1, 3'h0, 1'b0);
    u_ctrl.idle(49, 1'b1);
    `CHK(o_refresh_busy, 1'b1)
    u_ctrl.idle(2, 1'b1);
    `CHK(o_refresh_busy, 1'b0)
    rchk(8'h08, 32'h1);
    // precharge power-down, cke held low four edges, then high at least three
    u_ctrl.send(CMD_NOP, 1'b0, 3'h0, 1'b0);
    `CHK({o_pd_pre, o_pd_act, o_buf_en, o_dll_frozen}, 4'b1001)
    u_ctrl.idle(2, 1'b0);
    u_ctrl.send(CMD_NOP, 1'b1, 3'h0, 1'b0);
    `CHK({o_pd_pre, o_pd_act, o_buf_en, o_dll_frozen}, 4'b0010)
    u_ctrl.idle(2, 1'b1);
    // active power-down, fast then slow exit
    u_ctrl.send(CMD_ACT, 1'b1, 3'h2, 1'b0);
    for (int s = 0; s < 2; s++) begin
      wr(8'h00, 32'(s));
      rchk(8'h00, 32'(s));
      u_ctrl.send(CMD_NOP, 1'b0, 3'h0, 1'b0);
      `CHK({o_pd_pre, o_pd_act, o_buf_en, o_dll_frozen}, {3'b010, s[0]})
      rchk(8'h04, 32'h404);
      u_ctrl.idle(2, 1'b0);
      u_ctrl.send(CMD_NOP, 1'b1, 3'h0, 1'b0);
      u_ctrl.idle(2, 1'b1);
    end
    // self refresh with a row open is refused
    u_ctrl.send(CMD_REF, 1'b0, 3'h0, 1'b0);
    `CHK({o_sref, o_cmd_err}, 2'b01)
    u_ctrl.idle(2, 1'b0);
    u_ctrl.send(CMD_NOP, 1'b1, 3'h0, 1'b0);
    u_ctrl.idle(2, 1'b1);
    rchk(8'h04, 32'h2004);
    wr(8'h04, 32'h2000);
    rchk(8'h04, 32'h4);
    // cke may not fall beside an activate
    u_ctrl.send(CMD_ACT, 1'b0, 3'h6, 1'b0);
    `CHK(o_cmd_err, 1'b1)
    u_ctrl.idle(2, 1'b0);
    u_ctrl.send(CMD_NOP, 1'b1, 3'h0, 1'b0);
    u_ctrl.idle(2, 1'b1);
    wr(8'h04, 32'h2000);
    u_ctrl.send(CMD_PRE, 1'b1, 3'h6, 1'b0);
    u_ctrl.send(CMD_WR, 1'b1, 3'h2, 1'b1);
    `CHK(o_bank_open, 8'h00)
    u_ctrl.send(CMD_LM, 1'b1, 3'h0, 1'b0);
    `CHK({o_cmd_err, o_bank_open}, 9'h000)
    // self refresh entry, exit and the 200 cycle window
    u_ctrl.send(CMD_REF, 1'b0, 3'h0, 1'b0);
    `CHK({o_sref, o_refresh_busy, o_buf_en, o_dll_frozen}, 4'b1101)
    u_ctrl.idle(3, 1'b0);
    u_ctrl.send(CMD_NOP, 1'b1, 3'h0, 1'b0);
    `CHK({o_sref, o_buf_en}, 2'b01)
    u_ctrl.idle(199, 1'b1);
    rd(8'h04, d);
    `CHK(d[12], 1'b1)
    u_ctrl.idle(1, 1'b1);
    rd(8'h04, d);
    `CHK(d[12], 1'b0)
    rchk(8'h08, 32'h2);
    conclude();
  end
endmodule
